// file: design/rtcal_alarm_regs.sv
// How it works
// - Weekday mask at address Ah, bit 7 unused
// - Weekly hour at 9h, bits 7-6 zero
// - Daily minute at Bh, bits 6-0
// - Daily hour at Ch, bits 5-0
// - Weekly hour bit 5 is PM or tens-of-twenty
// - Daily hour bit 5 is PM or tens-of-twenty
// - Midnight codes 12, noon codes 32
// - Mask bit n matches weekday counter n
// - All-zero mask silences weekly alarm
`timescale 1ns/100ps
module rtcal_alarm_regs
(
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire rtcal_pkg::rtcal_req_t i_req,
  input wire rtcal_pkg::rtcal_time_t i_time,
  output logic [7:0] o_reg_rdata,
  output logic o_weekly_match,
  output logic o_daily_match
);

  // Stored alarm settings
  logic [rtcal_pkg::MINUTE_W-1:0] weekly_alarm_minute; // Weekly minute, BCD
  logic [rtcal_pkg::HOUR_W-1:0] weekly_alarm_hour; // Weekly hour, BCD
  logic [rtcal_pkg::MASK_W-1:0] weekday_mask_bits; // One bit per weekday value
  logic [rtcal_pkg::MINUTE_W-1:0] daily_alarm_minute; // Daily minute, BCD
  logic [rtcal_pkg::HOUR_W-1:0] daily_alarm_hour; // Daily hour, BCD

  // Combinational next values
  logic [7:0] next_rdata; // Read mux result
  logic next_weekly_match; // Weekly compare result
  logic next_daily_match; // Daily compare result

  // Field views of the stored hours and the daily minute
  logic weekly_alarm_hour_tens_hi; // PM flag or hour tens-of-twenty
  logic daily_alarm_pm_flag; // PM flag or hour tens-of-twenty
  logic daily_alarm_minute_tens_hi; // Minute tens-of-forty digit

  assign weekly_alarm_hour_tens_hi = weekly_alarm_hour[rtcal_pkg::HOUR_PM_BIT];
  assign daily_alarm_pm_flag = daily_alarm_hour[rtcal_pkg::HOUR_PM_BIT];
  assign daily_alarm_minute_tens_hi = daily_alarm_minute[rtcal_pkg::MINUTE_W-1];

  // Write strobe for one address
  function automatic logic wr_hit(input rtcal_pkg::rtcal_req_t req, input logic [3:0] addr);
    wr_hit = req.wr && (req.addr == addr);
  endfunction

  // Selects the mask bit of the current weekday; code 7 never matches
  function automatic logic day_hit(input logic [rtcal_pkg::MASK_W-1:0] mask,
                                   input logic [rtcal_pkg::WEEKDAY_W-1:0] day);
    logic hit;
    hit = 1'b0;
    if (day < 3'h7)
    begin
      hit = mask[day];
    end
    day_hit = hit;
  endfunction

  // Weekly minute register, bit 7 dropped on write
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      weekly_alarm_minute <= rtcal_pkg::RST_MINUTE;
    end
    else if (wr_hit(i_req, rtcal_pkg::ADDR_WEEKLY_MINUTE))
    begin
      weekly_alarm_minute <= i_req.wdata[rtcal_pkg::MINUTE_W-1:0];
    end
  end

  // Weekly hour register, bits 7-6 dropped on write
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      weekly_alarm_hour <= rtcal_pkg::RST_HOUR;
    end
    else if (wr_hit(i_req, rtcal_pkg::ADDR_WEEKLY_HOUR))
    begin
      weekly_alarm_hour <= i_req.wdata[rtcal_pkg::HOUR_W-1:0];
    end
  end

  // Weekday mask register, bit 7 dropped on write
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      weekday_mask_bits <= rtcal_pkg::RST_MASK;
    end
    else if (wr_hit(i_req, rtcal_pkg::ADDR_WEEKLY_DAY_MASK))
    begin
      weekday_mask_bits <= i_req.wdata[rtcal_pkg::MASK_W-1:0];
    end
  end

  // Daily minute register
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      daily_alarm_minute <= rtcal_pkg::RST_MINUTE;
    end
    else if (wr_hit(i_req, rtcal_pkg::ADDR_DAILY_MINUTE))
    begin
      daily_alarm_minute <= i_req.wdata[rtcal_pkg::MINUTE_W-1:0];
    end
  end

  // Daily hour register
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      daily_alarm_hour <= rtcal_pkg::RST_HOUR;
    end
    else if (wr_hit(i_req, rtcal_pkg::ADDR_DAILY_HOUR))
    begin
      daily_alarm_hour <= i_req.wdata[rtcal_pkg::HOUR_W-1:0];
    end
  end

  // Read mux, unused upper bits and other addresses read zero
  always_comb
  begin
    next_rdata = 8'h00;
    case (i_req.addr)
      rtcal_pkg::ADDR_WEEKLY_MINUTE: next_rdata = {1'b0, weekly_alarm_minute};
      rtcal_pkg::ADDR_WEEKLY_HOUR: next_rdata = {2'b00, weekly_alarm_hour};
      rtcal_pkg::ADDR_WEEKLY_DAY_MASK: next_rdata = {1'b0, weekday_mask_bits};
      rtcal_pkg::ADDR_DAILY_MINUTE: next_rdata = {1'b0, daily_alarm_minute};
      rtcal_pkg::ADDR_DAILY_HOUR: next_rdata = {2'b00, daily_alarm_hour};
      default: next_rdata = 8'h00;
    endcase
  end

  // Registered read data
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      o_reg_rdata <= rtcal_pkg::RST_RDATA;
    end
    else
    begin
      o_reg_rdata <= next_rdata;
    end
  end

  // Comparators; hour codes compared raw, so the counters share the mode
  always_comb
  begin
    // Bit 5 compared as stored: PM flag or tens digit alike
    next_daily_match = (daily_alarm_hour == i_time.hour) &&
                       (daily_alarm_minute == i_time.minute);
    // Empty mask never hits any weekday
    next_weekly_match = day_hit(weekday_mask_bits, i_time.weekday) &&
                        (weekly_alarm_hour == i_time.hour) &&
                        (weekly_alarm_minute == i_time.minute);
  end

  // Match outputs, a level while the time equals the setting
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      o_weekly_match <= 1'b0;
      o_daily_match <= 1'b0;
    end
    else
    begin
      o_weekly_match <= next_weekly_match;
      o_daily_match <= next_daily_match;
    end
  end

  // Mask write lands in the low seven bits
  chk_mask_write_lands: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_req.wr && i_req.addr == 4'ha) |=> (weekday_mask_bits == $past(i_req.wdata[6:0])))
    else $error("mask write lost");

  // Weekly hour write and read back with top bits zero
  chk_whour_readback: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_req.wr && i_req.addr == 4'h9) ##1 (i_req.addr == 4'h9 && !i_req.wr)
    |=> (o_reg_rdata == {2'b00, $past(i_req.wdata[5:0], 2)}))
    else $error("weekly hour readback wrong");

  // Daily minute write lands
  chk_dmin_write_lands: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_req.wr && i_req.addr == 4'hb) |=> (daily_alarm_minute == $past(i_req.wdata[6:0])))
    else $error("daily minute write lost");

  // Daily hour write lands
  chk_dhour_write_lands: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_req.wr && i_req.addr == 4'hc) |=> (daily_alarm_hour == $past(i_req.wdata[5:0])))
    else $error("daily hour write lost");

  // Weekly match needs bit 5 agreement
  chk_weekly_pm_agree: assert property (@(posedge i_core_clk) disable iff (i_srst)
    o_weekly_match |-> ($past(weekly_alarm_hour_tens_hi) == $past(i_time.hour[5])))
    else $error("weekly match with bit 5 mismatch");

  // Daily match needs bit 5 agreement
  chk_daily_pm_agree: assert property (@(posedge i_core_clk) disable iff (i_srst)
    o_daily_match |-> ($past(daily_alarm_pm_flag) == $past(i_time.hour[5])))
    else $error("daily match with bit 5 mismatch");

  // Noon code 32 matches counter code 32
  chk_noon_code: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (daily_alarm_hour == 6'h32 && i_time.hour == 6'h32 && daily_alarm_minute == i_time.minute)
    |=> o_daily_match)
    else $error("noon code did not match");

  // Weekly match only on a selected weekday
  chk_weekday_select: assert property (@(posedge i_core_clk) disable iff (i_srst)
    o_weekly_match |-> ($past(i_time.weekday) != 3'h7 &&
                        $past(weekday_mask_bits[i_time.weekday])))
    else $error("weekly match on unselected day");

  // Empty mask suppresses the weekly output
  chk_empty_mask: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (weekday_mask_bits == 7'h00) |=> !o_weekly_match)
    else $error("weekly match with empty mask");

  // Daily match follows the comparison one cycle later
  chk_daily_compare: assert property (@(posedge i_core_clk) disable iff (i_srst)
    ((daily_alarm_hour == i_time.hour) && (daily_alarm_minute == i_time.minute))
    |=> o_daily_match)
    else $error("daily match missed");

  // Mask read shows bit 7 as zero
  chk_mask_top_zero: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_req.addr == 4'ha) |=> (o_reg_rdata[7] == 1'b0 &&
                              o_reg_rdata[6:0] == $past(weekday_mask_bits)))
    else $error("mask read wrong");

  // Daily minute tens-of-forty reads back in bit 6
  chk_dmin_tens_read: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_req.addr == 4'hb) |=> (o_reg_rdata[6] == $past(daily_alarm_minute_tens_hi)))
    else $error("minute tens bit read wrong");

endmodule

// file: design/rtcal_pkg.sv
package rtcal_pkg;
  // Register addresses of the alarm group
  localparam logic [3:0] ADDR_WEEKLY_MINUTE = 4'h8;
  localparam logic [3:0] ADDR_WEEKLY_HOUR = 4'h9;
  localparam logic [3:0] ADDR_WEEKLY_DAY_MASK = 4'ha;
  localparam logic [3:0] ADDR_DAILY_MINUTE = 4'hb;
  localparam logic [3:0] ADDR_DAILY_HOUR = 4'hc;

  // Implemented field widths, low-aligned in each byte
  localparam int MINUTE_W = 7;
  localparam int HOUR_W = 6;
  localparam int MASK_W = 7;
  localparam int WEEKDAY_W = 3;

  // Position of the afternoon / tens-of-twenty bit in an hour byte
  localparam int HOUR_PM_BIT = 5;

  // Values after reset, every field cleared
  localparam logic [MINUTE_W-1:0] RST_MINUTE = 7'h00;
  localparam logic [HOUR_W-1:0] RST_HOUR = 6'h00;
  localparam logic [MASK_W-1:0] RST_MASK = 7'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;

  // Hour codes of midnight and noon in 12-hour mode
  localparam logic [HOUR_W-1:0] HOUR12_MIDNIGHT = 6'h12;
  localparam logic [HOUR_W-1:0] HOUR12_NOON = 6'h32;

  // Running time counters as seen by the comparators
  typedef struct packed {
    logic [WEEKDAY_W-1:0] weekday;
    logic [HOUR_W-1:0] hour;
    logic [MINUTE_W-1:0] minute;
  } rtcal_time_t;

  // One register access from the serial interface core
  typedef struct packed {
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } rtcal_req_t;
endpackage

// file: verification/rtcal_host_model.sv
`timescale 1ns/100ps
// Host side of the register port: one access per call
module rtcal_host_model
(
  input wire logic i_core_clk,
  output rtcal_pkg::rtcal_req_t o_req,
  output logic o_rd_due
);
  // Idle port at time zero
  initial
  begin
    o_req = '0;
    o_rd_due = 1'b0;
  end
  // One-cycle write pulse, then data released inverted
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    o_req <= {1'b1, a, d};
    @(posedge i_core_clk);
    o_req <= {1'b0, a, ~d};
  endtask
  // Address held two edges; flag marks the cycle the answer stands
  task automatic rd(input logic [3:0] a);
    @(posedge i_core_clk);
    o_req <= {1'b0, a, ~o_req.wdata};
    @(posedge i_core_clk);
    o_rd_due <= 1'b1;
    @(posedge i_core_clk);
    o_rd_due <= 1'b0;
  endtask
endmodule

// file: verification/tb_rtcal_alarm_regs.sv
`timescale 1ns/100ps
module tb_rtcal_alarm_regs;
  logic i_core_clk;
  logic i_srst;
  rtcal_pkg::rtcal_req_t req;
  rtcal_pkg::rtcal_time_t tm;
  logic [7:0] rdata;
  logic wmatch;
  logic dmatch;
  logic rd_due;
  logic m_due;
  logic [7:0] shadow [16]; // Expected register contents
  logic [7:0] rd_q [$];
  logic [1:0] m_q [$];
  int error_cnt;
  int checked;
  int cycles;
  // Free-running core clock
  initial
  begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  rtcal_alarm_regs dut_u (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_req(req), .i_time(tm),
    .o_reg_rdata(rdata), .o_weekly_match(wmatch), .o_daily_match(dmatch));
  rtcal_host_model host_u (.i_core_clk(i_core_clk), .o_req(req), .o_rd_due(rd_due));
  // Bits kept by each address
  function automatic logic [7:0] keep(input logic [3:0] a);
    case (a)
      4'h8, 4'ha, 4'hb: return 8'h7f;
      4'h9, 4'hc: return 8'h3f;
      default: return 8'h00;
    endcase
  endfunction
  // Closing report
  task automatic print_verdict();
    if (error_cnt == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Read data comparison
  task automatic cmp_rd(input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  // Match pair comparison, weekly then daily
  task automatic cmp_match(input logic [1:0] e, input logic [1:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  // Write with shadow update
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host_u.wr(a, d);
    shadow[a] = d & keep(a);
  endtask
  // Read with expectation noted
  task automatic rd(input logic [3:0] a);
    rd_q.push_back(shadow[a]);
    host_u.rd(a);
  endtask
  // Present a time and note the expected matches
  task automatic tcheck(input rtcal_pkg::rtcal_time_t t);
    logic [1:0] e;
    // Day index used directly as mask bit
    e[1] = t.weekday < 3'h7 && shadow[4'ha][t.weekday] && t.hour == shadow[4'h9][5:0]
      && t.minute == shadow[4'h8][6:0];
    e[0] = t.hour == shadow[4'hc][5:0] && t.minute == shadow[4'hb][6:0];
    m_q.push_back(e);
    @(posedge i_core_clk);
    tm <= t;
    @(posedge i_core_clk);
    m_due <= 1'b1;
    @(posedge i_core_clk);
    m_due <= 1'b0;
  endtask
  // Reset pulse, shadow back to cleared
  task automatic do_reset();
    i_srst <= 1'b1;
    repeat (5) @(posedge i_core_clk);
    i_srst <= 1'b0;
    foreach (shadow[i]) shadow[i] = 8'h00;
  endtask
  // Result monitor and hang guard
  always @(posedge i_core_clk)
  begin
    if (rd_due === 1'b1 && rd_q.size() > 0)
      cmp_rd(rd_q.pop_front(), rdata);
    if (m_due === 1'b1 && m_q.size() > 0)
      cmp_match(m_q.pop_front(), {wmatch, dmatch});
    cycles++;
    if (cycles > 20000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  // Main sequence
  initial
  begin
    i_srst = 1'b1;
    tm = '0;
    m_due = 1'b0;
    error_cnt = 0;
    checked = 0;
    cycles = 0;
    void'($urandom(32'hb4f0));
    do_reset();
    // Cleared values everywhere, unmapped included
    for (int a = 0; a < 16; a++)
      rd(4'(a));
    tcheck('0);
    // Random writes over mapped and unmapped places, then read back
    repeat (16)
      wr(4'h8 + 4'($urandom_range(0, 7)), 8'($urandom));
    for (int a = 8; a < 16; a++)
      rd(4'(a));
    // Weekly: mask bits 0..6 one at a time, then an empty mask, day counter swept 0..7
    wr(4'h9, 8'hf2);
    wr(4'h8, 8'hd9);
    for (int b = 0; b < 8; b++)
    begin
      wr(4'ha, 8'h80 | (8'h01 << b));
      for (int k = 0; k < 8; k++)
        tcheck({3'(k), 6'h32, 7'h59});
    end
    // Midnight and noon codes are distinct in both alarms
    wr(4'ha, 8'h7f);
    wr(4'h8, 8'h00);
    wr(4'hb, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      wr(4'h9, i == 0 ? 8'h12 : 8'h32);
      wr(4'hc, i == 0 ? 8'h32 : 8'h12);
      tcheck({3'h3, 6'h12, 7'h00});
      tcheck({3'h3, 6'h32, 7'h00});
    end
    // Random times near the daily setting
    repeat (16)
      tcheck({3'($urandom), shadow[4'hc][5:0] ^ 6'($urandom_range(0, 1)), shadow[4'hb][6:0]});
    // Second reset clears the written settings
    do_reset();
    for (int a = 8; a < 13; a++)
      rd(4'(a));
    // Let the monitor take the last result, then every note must be used
    @(posedge i_core_clk);
    if (rd_q.size() != 0 || m_q.size() != 0)
      error_cnt++;
    print_verdict();
  end
endmodule
